// >>> logic/buck_pkg.sv
// constants and types for the output voltage set-point control
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package buck_pkg;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] VOLT_ADDR   = 8'h00;
  localparam logic [7:0] RATE_ADDR   = 8'h04;
  localparam logic [7:0] CTRL_ADDR   = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;

  localparam int VCODE_W    = 6;
  localparam int RATE_W     = 2;
  localparam int GO_BIT     = 0;
  localparam int ST_DAC_LSB = 0;
  localparam int ST_BUSY    = 8;
  localparam int ST_RUN     = 9;
  localparam int ST_TGT_LSB = 16;
  localparam int ST_RATE_LSB = 24;

  // --------------------------------------------------------------------------
  // code range and defaults
  // --------------------------------------------------------------------------
  localparam logic [5:0] VCODE_MAX     = 6'h30;
  localparam logic [5:0] VCODE_DEFAULT = 6'h22;
  localparam logic [1:0] RATE_DEFAULT  = 2'h3;
  localparam int         STEP_UV       = 15000;
  localparam int         VMIN_MV       = 850;
  localparam int         VMAX_MV       = 1550;

  // --------------------------------------------------------------------------
  // timing: slew in tenths of mV/us, step interval in ns and cycles
  // --------------------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int RATE0_X10   = 9;
  localparam int RATE1_X10   = 38;
  localparam int RATE2_X10   = 75;
  localparam int RATE3_X10   = 113;
  localparam int STEP_NS0    = (STEP_UV * 10) / RATE0_X10;
  localparam int STEP_NS1    = (STEP_UV * 10) / RATE1_X10;
  localparam int STEP_NS2    = (STEP_UV * 10) / RATE2_X10;
  localparam int STEP_NS3    = (STEP_UV * 10) / RATE3_X10;
  localparam int TMR_W       = 10;
  localparam logic [9:0] STEP_CYC0 = 10'(STEP_NS0 / CLK_NS);
  localparam logic [9:0] STEP_CYC1 = 10'(STEP_NS1 / CLK_NS);
  localparam logic [9:0] STEP_CYC2 = 10'(STEP_NS2 / CLK_NS);
  localparam logic [9:0] STEP_CYC3 = 10'(STEP_NS3 / CLK_NS);

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    SLEW_IDLE,
    SLEW_RAMP
  } slew_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        acked;
  } reg_req_t;

  typedef struct packed {
    logic [5:0]  vshadow;
    logic [1:0]  rshadow;
    logic        go;
    logic [5:0]  target;
    logic [1:0]  rate_act;
    logic [5:0]  dac;
    logic [9:0]  timer;
    slew_state_t st;
    logic [31:0] rdata;
  } ctl_state_t;

  typedef struct packed {
    logic [2:0] sync;
    logic       level;
  } pin_state_t;

endpackage

// >>> logic/pin_sync3.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ns
module pin_sync3 (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      level_o
);

  buck_pkg::pin_state_t q;
  buck_pkg::pin_state_t d;

  // --------------------------------------------------------------------------
  // next state: level follows once stages two and three agree
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.sync = {q.sync[1:0], pin_i};
    if (q.sync[1] == q.sync[2]) begin
      d.level = q.sync[2];
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule

// >>> logic/buck_vout_setpoint_ctrl.sv
// output voltage set-point register, commit and slew limiter
`timescale 1ns/1ns
module buck_vout_setpoint_ctrl (
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire buck_pkg::reg_req_t  req_i,
  input  wire logic                run_i,
  output logic [31:0]              rdata_o,
  output logic [5:0]               dac_code_o,
  output logic                     busy_o,
  output logic                     regulator_en_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  buck_pkg::ctl_state_t q;
  buck_pkg::ctl_state_t d;
  logic                 run_level;
  logic                 go_rise;
  logic                 vol_wr;
  logic                 rate_wr;
  logic                 ctrl_wr;
  logic [9:0]           interval;
  logic [9:0]           new_interval;

  localparam buck_pkg::ctl_state_t RESET_STATE = '{
    vshadow:  buck_pkg::VCODE_DEFAULT,
    rshadow:  buck_pkg::RATE_DEFAULT,
    go:       1'b0,
    target:   buck_pkg::VCODE_DEFAULT,
    rate_act: buck_pkg::RATE_DEFAULT,
    dac:      buck_pkg::VCODE_DEFAULT,
    timer:    10'h000,
    st:       buck_pkg::SLEW_IDLE,
    rdata:    32'h0000_0000
  };

  // --------------------------------------------------------------------------
  // run pin input
  // --------------------------------------------------------------------------
  pin_sync3 u_run_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .pin_i     (run_i),
    .level_o   (run_level)
  );

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [9:0] step_cycles(input logic [1:0] code);
    logic [9:0] c;
    c = buck_pkg::STEP_CYC3;
    unique case (code)
      2'h0: c = buck_pkg::STEP_CYC0;
      2'h1: c = buck_pkg::STEP_CYC1;
      2'h2: c = buck_pkg::STEP_CYC2;
      2'h3: c = buck_pkg::STEP_CYC3;
    endcase
    return c;
  endfunction

  // effective target, saturated at the top code
  function automatic logic [5:0] sat_code(input logic [5:0] code);
    logic [5:0] s;
    s = code;
    if (code > buck_pkg::VCODE_MAX) begin
      s = buck_pkg::VCODE_MAX;
    end
    return s;
  endfunction

  // --------------------------------------------------------------------------
  // write decode: bytes count only once acknowledged
  // --------------------------------------------------------------------------
  always_comb begin
    vol_wr  = req_i.wr && req_i.acked &&
              (req_i.addr == buck_pkg::VOLT_ADDR);
    rate_wr = req_i.wr && req_i.acked &&
              (req_i.addr == buck_pkg::RATE_ADDR);
    ctrl_wr = req_i.wr && req_i.acked &&
              (req_i.addr == buck_pkg::CTRL_ADDR);
    go_rise = ctrl_wr && req_i.wdata[buck_pkg::GO_BIT] && !q.go;
    interval     = step_cycles(q.rate_act);
    new_interval = step_cycles(q.rshadow);
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;
    d.rdata = 32'h0000_0000;

    // shadow registers, untouched by the run pin
    if (vol_wr) begin
      d.vshadow = req_i.wdata[5:0];
    end
    if (rate_wr) begin
      d.rshadow = req_i.wdata[1:0];
    end
    if (ctrl_wr) begin
      d.go = req_i.wdata[buck_pkg::GO_BIT];
    end

    // slew limiter
    unique case (q.st)
      buck_pkg::SLEW_IDLE: begin
        if (q.dac != q.target) begin
          d.st    = buck_pkg::SLEW_RAMP;
          d.timer = interval - 10'h001;
        end
      end
      buck_pkg::SLEW_RAMP: begin
        if (q.dac == q.target) begin
          d.st = buck_pkg::SLEW_IDLE;
        end else if (q.timer == 10'h000) begin
          // one code is one voltage step
          if (q.dac < q.target) begin
            d.dac = q.dac + 6'h01;
          end else begin
            d.dac = q.dac - 6'h01;
          end
          d.timer = interval - 10'h001;
        end else begin
          d.timer = q.timer - 10'h001;
        end
      end
    endcase

    // commit restarts the interval at the new rate
    if (go_rise) begin
      d.target   = sat_code(q.vshadow);
      d.rate_act = q.rshadow;
      d.timer    = new_interval - 10'h001;
      d.st       = buck_pkg::SLEW_RAMP;
    end

    // read data, valid in the cycle after the strobe
    if (req_i.rd) begin
      unique case (req_i.addr)
        buck_pkg::VOLT_ADDR: begin
          d.rdata[5:0] = q.vshadow;
        end
        buck_pkg::RATE_ADDR: begin
          d.rdata[1:0] = q.rshadow;
        end
        buck_pkg::CTRL_ADDR: begin
          d.rdata[buck_pkg::GO_BIT] = q.go;
        end
        buck_pkg::STATUS_ADDR: begin
          d.rdata[buck_pkg::ST_DAC_LSB +: 6] = q.dac;
          d.rdata[buck_pkg::ST_BUSY]         = (q.st == buck_pkg::SLEW_RAMP);
          d.rdata[buck_pkg::ST_RUN]          = run_level;
          d.rdata[buck_pkg::ST_TGT_LSB +: 6] = q.target;
          d.rdata[buck_pkg::ST_RATE_LSB +: 2] = q.rate_act;
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers: reset is the main supply coming up
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign rdata_o        = q.rdata;
  assign dac_code_o     = q.dac;
  assign busy_o         = (q.st == buck_pkg::SLEW_RAMP);
  assign regulator_en_o = run_level;

  // --------------------------------------------------------------------------
  // checking helpers: cycles since last step or commit
  // --------------------------------------------------------------------------
  logic [9:0] since_q;
  logic       go_rise_q;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      since_q   <= 10'h000;
      go_rise_q <= 1'b0;
    end else begin
      go_rise_q <= go_rise;
      if (go_rise || (d.dac != q.dac)) begin
        since_q <= 10'h000;
      end else if (since_q != 10'h3ff) begin
        since_q <= since_q + 10'h001;
      end
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  AST_DAC_RANGE: assert property (
    dac_code_o <= buck_pkg::VCODE_MAX
  ) else $error("dac code above top code");

  AST_SATURATE: assert property (
    (go_rise && (q.vshadow > buck_pkg::VCODE_MAX))
      |=> (q.target == buck_pkg::VCODE_MAX)
  ) else $error("over-range code not saturated");

  AST_COMMIT_VALUE: assert property (
    (go_rise && (q.vshadow <= buck_pkg::VCODE_MAX))
      |=> (q.target == $past(q.vshadow))
  ) else $error("committed target differs from written code");

  AST_ONLY_ON_GO: assert property (
    ($changed(q.target) || $changed(q.rate_act)) |-> go_rise_q
  ) else $error("setting applied without update rising edge");

  AST_NACK_IGNORED: assert property (
    (req_i.wr && !req_i.acked)
      |=> ($stable(q.vshadow) && $stable(q.rshadow) && $stable(q.go))
  ) else $error("unacknowledged write changed a register");

  AST_RUN_KEEPS: assert property (
    ($changed(run_level) && !req_i.wr)
      |-> ##1 ($stable(q.vshadow) && $stable(q.rshadow) && $stable(q.target))
  ) else $error("run pin change altered stored codes");

  AST_STEP_ONE: assert property (
    $changed(dac_code_o) |->
      ((dac_code_o == $past(dac_code_o) + 6'h01) ||
       (dac_code_o == $past(dac_code_o) - 6'h01))
  ) else $error("dac moved by more than one code");

  AST_STEP_SPACING: assert property (
    $changed(dac_code_o) |-> ($past(since_q) >= $past(interval) - 10'h002)
  ) else $error("dac stepped faster than the selected rate");

  AST_RAMP_PROGRESS: assert property (
    (busy_o && (q.dac != q.target) && !go_rise)
      |-> ##[1:900] ($changed(dac_code_o) || go_rise)
  ) else $error("slew limiter stalled");

  AST_RAMP_ENDS: assert property (
    (busy_o && (q.dac == q.target) && !go_rise) |=> !busy_o
  ) else $error("limiter busy after reaching target");

  AST_READ_SLOT: assert property (
    !$past(req_i.rd) |-> (rdata_o == 32'h0000_0000)
  ) else $error("read data outside its slot");

  // --------------------------------------------------------------------------
  // assertions: defaults, stored fields and readback
  // --------------------------------------------------------------------------
  AST_SUPPLY_DEFAULTS: assert property (
    $fell(reset_i) |-> ((q.vshadow == buck_pkg::VCODE_DEFAULT) &&
      (q.rshadow == buck_pkg::RATE_DEFAULT) &&
      (dac_code_o == buck_pkg::VCODE_DEFAULT) && !busy_o)
  ) else $error("settings not at defaults after supply rise");

  AST_TARGET_RANGE: assert property (
    q.target <= buck_pkg::VCODE_MAX
  ) else $error("target above top code");

  AST_RATE_COMMIT: assert property (
    go_rise |=> (q.rate_act == $past(q.rshadow))
  ) else $error("committed rate differs from written code");

  AST_BUSY_ON_COMMIT: assert property (
    go_rise |=> busy_o
  ) else $error("limiter idle after commit");

  AST_IDLE_HOLDS: assert property (
    (!busy_o && !go_rise) |=> $stable(dac_code_o)
  ) else $error("dac moved while limiter idle");

  AST_STEP_TOWARD: assert property (
    $changed(dac_code_o) |-> ($past(q.dac) != $past(q.target))
  ) else $error("dac stepped while at target");

  AST_VOLT_WRITE: assert property (
    vol_wr |=> (q.vshadow == $past(req_i.wdata[5:0]))
  ) else $error("acknowledged voltage write not stored");

  AST_RATE_WRITE: assert property (
    rate_wr |=> (q.rshadow == $past(req_i.wdata[1:0]))
  ) else $error("acknowledged rate write not stored");

  AST_GO_STORED: assert property (
    ctrl_wr |=> (q.go == $past(req_i.wdata[buck_pkg::GO_BIT]))
  ) else $error("update bit not stored");

  AST_READ_VOLT: assert property (
    (req_i.rd && (req_i.addr == buck_pkg::VOLT_ADDR))
      |=> (rdata_o == {26'h0, $past(q.vshadow)})
  ) else $error("voltage readback wrong");

  AST_READ_RATE: assert property (
    (req_i.rd && (req_i.addr == buck_pkg::RATE_ADDR))
      |=> (rdata_o == {30'h0, $past(q.rshadow)})
  ) else $error("rate readback wrong");

endmodule

// >>> bench/host_model.sv
// host side register bus driver for the set-point block
`timescale 1ns/1ns
module host_model (
  input  wire logic          sys_clk_i,
  input  wire logic [31:0]   rdata_i,
  output buck_pkg::reg_req_t req_o
);
  initial req_o = '0;
  // one write; ack low models an unacknowledged byte
  task automatic put(input logic [7:0] a, input logic [31:0] d,
                     input logic ack);
    @(posedge sys_clk_i);
    req_o.addr  <= a;
    req_o.wdata <= d;
    req_o.wr    <= 1'b1;
    req_o.acked <= ack;
    @(posedge sys_clk_i);
    req_o.wr    <= 1'b0;
    req_o.acked <= 1'b0;
    req_o.wdata <= ~d;
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    req_o.addr <= a;
    req_o.rd   <= 1'b1;
    @(posedge sys_clk_i);
    req_o.rd   <= 1'b0;
    @(negedge sys_clk_i);
    d = rdata_i;
  endtask
  // clear then set the update bit so that it rises
  task automatic commit();
    put(buck_pkg::CTRL_ADDR, 32'h0, 1'b1);
    put(buck_pkg::CTRL_ADDR, 32'h1, 1'b1);
  endtask
endmodule

// >>> bench/tb_buck_vout_setpoint_ctrl.sv
// self-checking bench for the output voltage set-point block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_buck_vout_setpoint_ctrl;
  logic               sys_clk_i = 1'b0;
  logic               reset_i = 1'b1;
  logic               run_i = 1'b0;
  buck_pkg::reg_req_t req;
  logic [31:0]        rdata;
  logic [31:0]        v;
  logic [5:0]         dac;
  logic               busy;
  logic               reg_en;
  int                 fails = 0;
  int                 checks_done = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  buck_vout_setpoint_ctrl dut (
    .sys_clk_i      (sys_clk_i),
    .reset_i        (reset_i),
    .req_i          (req),
    .run_i          (run_i),
    .rdata_o        (rdata),
    .dac_code_o     (dac),
    .busy_o         (busy),
    .regulator_en_o (reg_en)
  );
  host_model host (
    .sys_clk_i (sys_clk_i),
    .rdata_i   (rdata),
    .req_o     (req)
  );
  always @(negedge sys_clk_i)
    if (!reset_i && dac > 6'h30) `CHK("dac_range", 6'h30, dac)
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude();
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(negedge sys_clk_i);
      n++;
    end
    `CHK("ramp_done", 1'b0, busy)
  endtask
  task automatic step_gap(input int cyc);
    int n;
    logic [5:0] s;
    s = dac;
    n = 0;
    while (dac === s && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    `CHK("step_gap", 1'b1, (n >= cyc - 1 && n <= cyc + 3))
  endtask
  function automatic logic [5:0] tgt(input logic [31:0] s);
    return s[buck_pkg::ST_TGT_LSB +: 6];
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults();
    `CHK("dac_rst", 6'h22, dac)
    host.get(buck_pkg::STATUS_ADDR, v);
    `CHK("tgt_rst", 6'h22, tgt(v))
    `CHK("rate_rst", 2'h3, v[buck_pkg::ST_RATE_LSB +: 2])
    host.get(buck_pkg::RATE_ADDR, v);
    `CHK("rate_reg", 32'h3, v)
    host.get(8'h10, v);
    `CHK("unmapped", 32'h0, v)
    @(negedge sys_clk_i);
    `CHK("rdata_idle", 32'h0, rdata)
  endtask
  task automatic t_clamp();
    host.put(buck_pkg::VOLT_ADDR, 32'h3f, 1'b1);
    host.put(buck_pkg::RATE_ADDR, 32'h3, 1'b1);
    host.get(buck_pkg::STATUS_ADDR, v);
    `CHK("no_commit", 6'h22, tgt(v))
    host.commit();
    step_gap(buck_pkg::STEP_CYC3);
    `CHK("one_step", 6'h23, dac)
    host.get(buck_pkg::STATUS_ADDR, v);
    `CHK("tgt_sat", 6'h30, tgt(v))
    `CHK("busy_ramp", 1'b1, v[buck_pkg::ST_BUSY])
    wait_idle();
    `CHK("dac_sat", 6'h30, dac)
  endtask
  task automatic t_guard();
    host.put(buck_pkg::VOLT_ADDR, 32'h05, 1'b0);
    host.get(buck_pkg::VOLT_ADDR, v);
    `CHK("nack_wr", 32'h3f, v)
    host.put(buck_pkg::VOLT_ADDR, 32'h0a, 1'b1);
    host.put(buck_pkg::CTRL_ADDR, 32'h1, 1'b1);
    host.get(buck_pkg::CTRL_ADDR, v);
    `CHK("go_kept", 32'h1, v)
    host.put(buck_pkg::STATUS_ADDR, 32'h0, 1'b1);
    host.get(buck_pkg::STATUS_ADDR, v);
    `CHK("no_rise", 6'h30, tgt(v))
    `CHK("no_ramp", 1'b0, busy)
  endtask
  task automatic t_rates();
    int cyc[4];
    cyc = '{buck_pkg::STEP_CYC0, buck_pkg::STEP_CYC1,
            buck_pkg::STEP_CYC2, buck_pkg::STEP_CYC3};
    for (int r = 0; r < 4; r++) begin
      host.put(buck_pkg::RATE_ADDR, 32'(r), 1'b1);
      host.put(buck_pkg::VOLT_ADDR, 32'(47 - r), 1'b1);
      host.commit();
      step_gap(cyc[r]);
      host.get(buck_pkg::STATUS_ADDR, v);
      `CHK("rate_act", 2'(r), v[buck_pkg::ST_RATE_LSB +: 2])
      wait_idle();
      `CHK("dac_rate", 6'(47 - r), dac)
    end
  endtask
  task automatic t_run();
    @(posedge sys_clk_i);
    run_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("run_on", 1'b1, reg_en)
    host.get(buck_pkg::STATUS_ADDR, v);
    `CHK("run_status", 1'b1, v[buck_pkg::ST_RUN])
    @(posedge sys_clk_i);
    run_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    `CHK("run_off", 1'b0, reg_en)
    host.get(buck_pkg::VOLT_ADDR, v);
    `CHK("run_volt", 32'h2c, v)
    host.get(buck_pkg::RATE_ADDR, v);
    `CHK("run_rate", 32'h3, v)
    `CHK("run_dac", 6'h2c, dac)
  endtask
  task automatic t_reset_mid();
    host.put(buck_pkg::VOLT_ADDR, 32'h0, 1'b1);
    host.commit();
    repeat (200) @(posedge sys_clk_i);
    reset_i <= 1'b1;
    @(negedge sys_clk_i);
    `CHK("rst_dac", 6'h22, dac)
    `CHK("rst_busy", 1'b0, busy)
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    host.get(buck_pkg::VOLT_ADDR, v);
    `CHK("rst_volt", 32'h22, v)
    host.get(buck_pkg::RATE_ADDR, v);
    `CHK("rst_rate", 32'h3, v)
  endtask
  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_defaults();
    t_clamp();
    t_guard();
    t_rates();
    t_run();
    t_reset_mid();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    conclude();
  end
endmodule
